// [src/csp_pkg.sv]
// package: constants, carriers and decode functions for current-sense configuration
// Operation
// - queue field sets 1 to 4 consecutive out-of-limit results
// - averaging field selects 1x 2x 4x 8x
// - sample time code: 82, 82, 164, 328 ms
// - result updates every sample time times averaging
// - range field selects 10 20 40 80 mV
// - sampling register resets to 03h
// - spike detector always uses current register contents
// - straps seed spike register, host write replaces them
// - host may rewrite spike fields any time
// - threshold is 10 mV plus 5 mV per code
// - duration code maps 1 ms to 4096 ms
// - route bit picks alert or critical pin
// - each new result compared against high, low limits
// - result is 12-bit two's complement value
package csp_pkg;

	// ----------------------------------------
	// register map and reset values
	// ----------------------------------------
	localparam logic [7:0] ADDR_SAMP_CFG = 8'h51;
	localparam logic [7:0] ADDR_SPIKE_CFG = 8'h52;
	localparam logic [7:0] SAMP_CFG_RST = 8'h03;
	localparam logic [7:0] SPIKE_CFG_RST = 8'h00;
	localparam int QUEUE_LSB = 6;
	localparam int AVG_LSB = 4;
	localparam int TIME_LSB = 2;
	localparam int RANGE_LSB = 0;
	localparam int THR_LSB = 4;
	localparam int DUR_LSB = 0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 40;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int SAMP_BASE_MS = 82;
	localparam int THR_BASE_MV = 10;
	localparam int THR_STEP_MV = 5;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ----------------------------------------
	// carriers and state
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csp_reg_req_t;

	typedef struct packed {
		logic [7:0] samp_cfg;
		logic [7:0] spike_cfg;
		logic strap_pending;
		logic [1:0] strap_wait;
		logic [7:0] sy1;
		logic [7:0] sy2;
		logic [7:0] sy3;
		logic [15:0] tick_cnt;
		logic tick;
		logic [13:0] period_cnt;
		logic conv_start;
		logic [3:0] avg_cnt;
		logic signed [14:0] acc;
		logic [11:0] result;
		logic result_upd;
		logic [2:0] queue_cnt;
		logic high_evt;
		logic low_evt;
		logic [7:0] rdata;
	} csp_main_st_t;

	localparam csp_main_st_t MAIN_RST = '{samp_cfg: SAMP_CFG_RST, spike_cfg: SPIKE_CFG_RST,
		strap_pending: 1'b1, strap_wait: STRAP_SETTLE, default: '0};

	typedef struct packed {
		logic [7:0] m1;
		logic [7:0] m2;
		logic [7:0] m3;
		logic [7:0] mag;
		logic [16:0] cnt;
		logic active;
		logic alert;
		logic crit_n;
	} csp_spike_st_t;

	localparam csp_spike_st_t SPIKE_RST = '{crit_n: 1'b1, default: '0};

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	// sample time in ticks
	function automatic logic [13:0] samp_ticks(input logic [1:0] code);
		int ms;
		ms = (code == 2'h3) ? SAMP_BASE_MS * 4 : (code == 2'h2) ? SAMP_BASE_MS * 2 : SAMP_BASE_MS;
		return 14'(ms * 1000 / TICK_US);
	endfunction

	// last sample index of an averaging run
	function automatic logic [3:0] avg_last(input logic [1:0] code);
		return 4'((4'h1 << code) - 4'h1);
	endfunction

	// threshold in mV
	function automatic logic [7:0] thr_mv(input logic [3:0] code);
		return 8'(THR_BASE_MV + THR_STEP_MV * int'(code));
	endfunction

	// minimum duration in ticks
	function automatic logic [16:0] dur_ticks(input logic [3:0] code);
		int us;
		case (code)
			4'h0: us = 1000;
			4'h1: us = 5120;
			4'h2: us = 25600;
			4'h3: us = 51200;
			4'h4: us = 76800;
			4'h5: us = 102400;
			4'h6: us = 128000;
			4'h7: us = 256000;
			4'h8: us = 384000;
			4'h9: us = 512000;
			4'hA: us = 768000;
			4'hB: us = 1024000;
			4'hC: us = 1536000;
			4'hD: us = 2048000;
			4'hE: us = 3072000;
			default: us = 4096000;
		endcase
		return 17'(us / TICK_US);
	endfunction

endpackage

// [src/csp_spike_timer.sv]
// spike detector: threshold compare, duration timer and output routing
`timescale 1ns/100ps
module csp_spike_timer import csp_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tick,
	input wire logic [7:0] spike_magnitude_mv,
	input wire logic [3:0] spike_threshold_code,
	input wire logic [3:0] spike_min_duration_code,
	input wire logic spike_output_route,
	output logic spike_active,
	output logic spike_alert,
	output logic critical_fault_pin_n
);

	csp_spike_st_t st;
	csp_spike_st_t next_st;
	logic above;
	logic [16:0] target;

	// ----------------------------------------
	// compare and timer
	// ----------------------------------------
	assign above = st.mag > thr_mv(spike_threshold_code);
	assign target = dur_ticks(spike_min_duration_code);

	always_comb begin
		next_st = st;
		// magnitude pin sync, taken once stages two and three agree
		next_st.m1 = spike_magnitude_mv;
		next_st.m2 = st.m1;
		next_st.m3 = st.m2;
		if (st.m2 == st.m3) begin
			next_st.mag = st.m3;
		end
		// timer restarts whenever magnitude is at or below threshold
		if (!above) begin
			next_st.cnt = '0;
		end else if (tick && st.cnt < target) begin
			next_st.cnt = st.cnt + 17'h00001;
		end
		next_st.active = above && next_st.cnt >= target;
		next_st.alert = next_st.active && !spike_output_route;
		next_st.crit_n = !(next_st.active && spike_output_route);
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= SPIKE_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign spike_active = st.active;
	assign spike_alert = st.alert;
	assign critical_fault_pin_n = st.crit_n;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_spike_restart: assert property (ce && !above |=> !st.active && st.cnt == '0)
		else $error("spike timer did not restart");
	a_spike_min_time: assert property (ce && st.cnt < target |=> !st.active || $past(tick))
		else $error("spike flagged before duration");
	a_spike_below_thr: assert property (ce && st.mag <= thr_mv(spike_threshold_code) |=>
		!st.active)
		else $error("spike flagged at or below threshold");
	a_spike_route_crit: assert property (ce && !spike_output_route |=> st.crit_n)
		else $error("critical pin driven while routed to alert");
	c_spike_alert: cover property (st.active && st.alert);

endmodule

// [src/csp_sense_config.sv]
// current-sense configuration registers, update timing, averaging and limit queue
`timescale 1ns/100ps
module csp_sense_config import csp_pkg::*; #(
	parameter int TICK_COUNT = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire csp_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] threshold_strap_pin,
	input wire logic [3:0] duration_strap_pin,
	input wire logic sample_valid,
	input wire logic [11:0] sample_data,
	input wire logic [7:0] sense_high_limit,
	input wire logic [7:0] sense_low_limit,
	input wire logic [7:0] spike_magnitude_mv,
	input wire logic spike_output_route,
	output logic conv_start,
	output logic [1:0] sense_full_scale_select,
	output logic [1:0] sense_average_count,
	output logic [1:0] sense_sample_period,
	output logic [11:0] shunt_voltage_result,
	output logic result_update,
	output logic sense_high_event,
	output logic sense_low_event,
	output logic spike_active,
	output logic spike_alert,
	output logic critical_fault_pin_n
);

	csp_main_st_t st;
	csp_main_st_t next_st;
	logic signed [14:0] sum_all;
	logic signed [14:0] avg_val;
	logic [1:0] queue_code;
	logic [1:0] avg_code;
	logic [1:0] time_code;
	logic [2:0] depth;
	logic [2:0] queue_inc;
	logic hit_high;
	logic hit_low;
	logic wr_samp;
	logic wr_spike;

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	assign queue_code = st.samp_cfg[QUEUE_LSB+:2];
	assign avg_code = st.samp_cfg[AVG_LSB+:2];
	assign time_code = st.samp_cfg[TIME_LSB+:2];
	assign depth = {1'b0, queue_code} + 3'h1;
	assign queue_inc = (st.queue_cnt < depth) ? st.queue_cnt + 3'h1 : st.queue_cnt;
	assign wr_samp = reg_req.wr && reg_req.addr == ADDR_SAMP_CFG;
	assign wr_spike = reg_req.wr && reg_req.addr == ADDR_SPIKE_CFG;

	// sign-extended running sum and averaged value
	assign sum_all = st.acc + {{3{sample_data[11]}}, sample_data};
	assign avg_val = sum_all >>> avg_code;

	// limit comparison on the signed high byte of the result
	assign hit_high = $signed(st.result[11:4]) >= $signed(sense_high_limit);
	assign hit_low = $signed(st.result[11:4]) < $signed(sense_low_limit);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		next_st.conv_start = 1'b0;
		next_st.result_upd = 1'b0;
		next_st.high_evt = 1'b0;
		next_st.low_evt = 1'b0;

		// strap pins, three-stage sync
		next_st.sy1 = {threshold_strap_pin, duration_strap_pin};
		next_st.sy2 = st.sy1;
		next_st.sy3 = st.sy2;
		if (st.strap_wait != 2'h0) begin
			next_st.strap_wait = st.strap_wait - 2'h1;
		end

		// register writes; a spike write beats a pending strap load
		if (wr_samp) begin
			next_st.samp_cfg = reg_req.wdata;
		end
		// strap load runs beside sampling writes so they never delay it
		if (wr_spike) begin
			next_st.spike_cfg = reg_req.wdata;
			next_st.strap_pending = 1'b0;
		end else if (st.strap_pending && st.strap_wait == 2'h0 && st.sy2 == st.sy3) begin
			next_st.spike_cfg = st.sy3;
			next_st.strap_pending = 1'b0;
		end

		// register read data
		if (reg_req.rd) begin
			if (reg_req.addr == ADDR_SAMP_CFG) begin
				next_st.rdata = st.samp_cfg;
			end else if (reg_req.addr == ADDR_SPIKE_CFG) begin
				next_st.rdata = st.spike_cfg;
			end else begin
				next_st.rdata = 8'h00;
			end
		end

		// time base tick
		if (st.tick_cnt >= 16'(TICK_COUNT - 1)) begin
			next_st.tick_cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 16'h0001;
		end

		// one conversion per sample time
		if (st.tick) begin
			if (st.period_cnt >= samp_ticks(time_code) - 14'h0001) begin
				next_st.period_cnt = 14'h0000;
				next_st.conv_start = 1'b1;
			end else begin
				next_st.period_cnt = st.period_cnt + 14'h0001;
			end
		end

		// averaging: result once per averaging run
		if (sample_valid) begin
			if (st.avg_cnt >= avg_last(avg_code)) begin
				next_st.result = avg_val[11:0];
				next_st.result_upd = 1'b1;
				next_st.acc = 15'sh0000;
				next_st.avg_cnt = 4'h0;
			end else begin
				next_st.acc = sum_all;
				next_st.avg_cnt = st.avg_cnt + 4'h1;
			end
		end

		// consecutive out-of-limit queue
		if (st.result_upd) begin
			if (hit_high || hit_low) begin
				next_st.queue_cnt = queue_inc;
				if (queue_inc >= depth) begin
					next_st.high_evt = hit_high;
					next_st.low_evt = hit_low;
				end
			end else begin
				next_st.queue_cnt = 3'h0;
			end
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= MAIN_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = st.rdata;
	assign conv_start = st.conv_start;
	assign sense_full_scale_select = st.samp_cfg[RANGE_LSB+:2];
	assign sense_average_count = avg_code;
	assign sense_sample_period = time_code;
	assign shunt_voltage_result = st.result;
	assign result_update = st.result_upd;
	assign sense_high_event = st.high_evt;
	assign sense_low_event = st.low_evt;

	// spike detector fed straight from the live register
	csp_spike_timer u_spike (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.tick(st.tick),
		.spike_magnitude_mv(spike_magnitude_mv),
		.spike_threshold_code(st.spike_cfg[THR_LSB+:4]),
		.spike_min_duration_code(st.spike_cfg[DUR_LSB+:4]),
		.spike_output_route(spike_output_route),
		.spike_active(spike_active),
		.spike_alert(spike_alert),
		.critical_fault_pin_n(critical_fault_pin_n)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_reset_samp_cfg: assert property (disable iff (1'b0) reset ##1 !reset |->
		st.samp_cfg == SAMP_CFG_RST)
		else $error("sampling config not at reset value");
	a_write_samp_cfg: assert property (ce && wr_samp |=> st.samp_cfg == $past(reg_req.wdata))
		else $error("sampling config write lost");
	a_write_spike_cfg: assert property (ce && wr_spike |=>
		st.spike_cfg == $past(reg_req.wdata) && !st.strap_pending)
		else $error("spike config write lost");
	a_strap_seed: assert property (ce && !wr_spike && st.strap_pending &&
		st.strap_wait == 2'h0 && st.sy2 == st.sy3 |=> st.spike_cfg == $past(st.sy3))
		else $error("strap value not loaded");
	a_avg_update: assert property (ce && sample_valid &&
		st.avg_cnt >= avg_last(avg_code) |=> st.result_upd)
		else $error("result not updated after averaging run");
	a_avg_no_early: assert property (ce && sample_valid &&
		st.avg_cnt < avg_last(avg_code) |=> !st.result_upd)
		else $error("result updated before run complete");
	a_period_start: assert property (ce && st.tick &&
		st.period_cnt == samp_ticks(time_code) - 14'h0001 |=> st.conv_start)
		else $error("conversion start missing");
	a_queue_event: assert property (st.high_evt || st.low_evt |->
		st.queue_cnt >= $past(depth))
		else $error("limit event before queue depth");
	a_limit_count: assert property (ce && st.result_upd && !hit_high && !hit_low |=>
		st.queue_cnt == 3'h0)
		else $error("queue not cleared on in-limit result");

	c_high_event: cover property (st.high_evt);
	c_avg_eight: cover property (st.result_upd && avg_code == 2'h3);
	c_strap_loaded: cover property (st.strap_pending ##1 !st.strap_pending);

endmodule

// [tb/csp_host_model.sv]
// host side model: byte strobe register access
`timescale 1ns/100ps
module csp_host_model import csp_pkg::*; (
	input wire logic clk,
	output csp_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_req = '0;
	end
	// ----------------------------------------
	// access tasks, driven on the falling edge
	// ----------------------------------------
	// one-cycle write strobe, accepted on any cycle with ce high
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// one-cycle read strobe, data taken once registered
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
		@(negedge clk);
		d = reg_rdata;
	endtask
endmodule

// [tb/testbench.sv]
// testbench: registers, averaging, limit queue, update timing and spike detector
`timescale 1ns/100ps
module testbench import csp_pkg::*; ;
	logic clk, reset, ce, sample_valid, spike_output_route;
	logic [11:0] sample_data, shunt_voltage_result;
	logic [7:0] sense_high_limit, sense_low_limit, spike_magnitude_mv, reg_rdata;
	logic [3:0] threshold_strap_pin, duration_strap_pin;
	logic [1:0] sense_full_scale_select, sense_average_count, sense_sample_period;
	logic conv_start, result_update, sense_high_event, sense_low_event;
	logic spike_active, spike_alert, critical_fault_pin_n, hi, lo;
	csp_reg_req_t reg_req;
	int n_errors = 0;
	int n_compared = 0;
	int n_upd = 0;
	int u, g;
	logic [7:0] v;

	csp_host_model csp_host_model_inst (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
	csp_sense_config #(.TICK_COUNT(4)) csp_sense_config_inst (
		.clk(clk), .reset(reset), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.threshold_strap_pin(threshold_strap_pin), .duration_strap_pin(duration_strap_pin),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.sense_high_limit(sense_high_limit), .sense_low_limit(sense_low_limit),
		.spike_magnitude_mv(spike_magnitude_mv), .spike_output_route(spike_output_route),
		.conv_start(conv_start), .sense_full_scale_select(sense_full_scale_select),
		.sense_average_count(sense_average_count), .sense_sample_period(sense_sample_period),
		.shunt_voltage_result(shunt_voltage_result), .result_update(result_update),
		.sense_high_event(sense_high_event), .sense_low_event(sense_low_event),
		.spike_active(spike_active), .spike_alert(spike_alert),
		.critical_fault_pin_n(critical_fault_pin_n));

	// ----------------------------------------
	// clock, update counter, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// counts result pulses where they are settled
	always @(negedge clk) begin
		if (result_update === 1'b1) n_upd++;
	end
	initial begin
		#800000;
		n_errors++;
		report_and_stop();
	end

	// ----------------------------------------
	// compare, report and stimulus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_rng(input string nm, input int e0, input int e1, input int s);
		n_compared++;
		if (s < e0 || s > e1) begin
			n_errors++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, e0, e1, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		csp_host_model_inst.rd(a, d);
		chk(nm, 12'(e), 12'(d));
	endtask
	// one sample, then gather the event pulses that follow it
	task automatic smp(input logic [11:0] d);
		hi = 1'b0;
		lo = 1'b0;
		@(negedge clk);
		sample_valid = 1'b1;
		sample_data = d;
		@(negedge clk);
		sample_valid = 1'b0;
		sample_data = ~d;
		repeat (4) begin
			@(negedge clk);
			hi = hi | sense_high_event;
			lo = lo | sense_low_event;
		end
	endtask
	// cycles between two conversion requests
	task automatic conv_gap();
		int k;
		k = 0;
		while (conv_start !== 1'b1 && k < 40000) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		g = 1;
		while (conv_start !== 1'b1 && g < 40000) begin
			@(negedge clk);
			g++;
		end
	endtask
	// spike run: e is the expected delay in cycles, 0 for none
	task automatic spk(input logic [7:0] c, input logic rt, input logic [7:0] m, input int e);
		int k;
		csp_host_model_inst.wr(ADDR_SPIKE_CFG, c);
		spike_output_route = rt;
		spike_magnitude_mv = m;
		k = 0;
		while (spike_active !== 1'b1 && k < 700) begin
			@(negedge clk);
			k++;
		end
		if (e == 0) begin
			chk_rng("spike none", 700, 700, k);
		end else begin
			chk_rng("spike delay", e - 4, e + 12, k);
			@(negedge clk);
			chk("alert", 12'(!rt), 12'(spike_alert));
			chk("critical", 12'(!rt), 12'(critical_fault_pin_n));
		end
		spike_magnitude_mv = 8'h00;
		repeat (10) @(negedge clk);
		chk("spike off", 12'h000, 12'(spike_active));
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		sample_valid = 1'b0;
		sample_data = 12'h000;
		sense_high_limit = 8'h10;
		sense_low_limit = 8'hF0;
		spike_magnitude_mv = 8'h00;
		spike_output_route = 1'b1;
		threshold_strap_pin = 4'hA;
		duration_strap_pin = 4'h5;
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		chk("range", 12'h003, 12'(sense_full_scale_select));
		chk("avg", 12'h000, 12'(sense_average_count));
		chk("period", 12'h000, 12'(sense_sample_period));
		rchk("samp cfg", 8'h51, 8'h03);
		repeat (8) @(negedge clk);
		rchk("strap", 8'h52, 8'hA5);
		rchk("unmapped", 8'h50, 8'h00);
		rchk("unmapped", 8'h53, 8'h00);
		// every code of every field
		for (int i = 0; i < 4; i++) begin
			v = {4{2'(i)}};
			csp_host_model_inst.wr(8'h51, v);
			chk("range", 12'(i), 12'(sense_full_scale_select));
			chk("avg", 12'(i), 12'(sense_average_count));
			chk("period", 12'(i), 12'(sense_sample_period));
			rchk("samp cfg", 8'h51, v);
		end
		// clock enable low: a write is ignored and the register holds
		ce = 1'b0;
		csp_host_model_inst.wr(8'h51, 8'h00);
		chk("ce hold", 12'h003, 12'(sense_full_scale_select));
		ce = 1'b1;
		rchk("ce hold cfg", 8'h51, 8'hFF);
		// floor average of -2 and n-1 times -1 is -2 for every factor
		for (int a = 0; a < 4; a++) begin
			csp_host_model_inst.wr(8'h51, {2'b00, 2'(a), 4'b0011});
			u = n_upd;
			for (int k = 0; k < (1 << a); k++) begin
				smp((k == 0) ? 12'hFFE : 12'hFFF);
				if (k == (1 << a) - 2) chk("early update", 12'h000, 12'(n_upd - u));
			end
			chk("updates", 12'h001, 12'(n_upd - u));
			chk("result", 12'hFFE, shunt_voltage_result);
		end
		// queue depth three, in-limit result clears the count, limit boundaries
		csp_host_model_inst.wr(8'h51, 8'h83);
		for (int k = 0; k < 4; k++) begin
			smp(12'h100);
			chk("high event", 12'(k >= 2), 12'(hi));
		end
		chk("result", 12'h100, shunt_voltage_result);
		smp(12'hF00);
		chk("low miss", 12'h000, 12'(lo));
		for (int k = 0; k < 3; k++) begin
			smp(12'hE00);
			chk("low event", 12'(k == 2), 12'(lo));
		end
		// conversion request spacing
		for (int c = 1; c < 3; c++) begin
			csp_host_model_inst.wr(8'h51, {4'b0000, 2'(c), 2'b11});
			conv_gap();
			chk_rng("conv gap", 8200 * c, 8200 * c, g);
		end
		spk(8'h00, 1'b1, 8'd11, 100);
		spk(8'h00, 1'b0, 8'd10, 0);
		spk(8'hF1, 1'b0, 8'd86, 512);
		spk(8'hF0, 1'b1, 8'd85, 0);
		rchk("spike cfg", 8'h52, 8'hF0);
		// mid-run reset: sampling register back to 03h, straps seed again
		@(negedge clk);
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		chk("period", 12'h000, 12'(sense_sample_period));
		rchk("samp cfg", 8'h51, 8'h03);
		repeat (8) @(negedge clk);
		rchk("strap", 8'h52, 8'hA5);
		report_and_stop();
	end
endmodule
